// ---- design/dsr_pkg.sv ----
// Purpose: shared constants and types of the diagnostics, self-test and data ready block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: register byte address is four times its printed index
package dsr_pkg;
  // register indices, byte address = index * 4
  localparam logic [7:0] IDX_FLASH_WRITE_COUNTER = 8'h00;
  localparam logic [7:0] IDX_AUX_DAC = 8'h30;
  localparam logic [7:0] IDX_MISC = 8'h34;
  localparam logic [7:0] IDX_DIAG = 8'h3c;
  localparam logic [7:0] IDX_GLOB = 8'h3e;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
  localparam int ADDR_W = 10;

  // misc control fields
  localparam logic [15:0] MISC_RESET = 16'h0006;
  localparam int MISC_DR_EN = 2;
  localparam int MISC_DR_POL = 1;
  localparam int MISC_DR_SEL = 0;
  localparam int MISC_ST_POS = 8;
  localparam int MISC_ST_NEG = 9;
  localparam int MISC_ST_AUTO = 10;
  localparam int MISC_MEM_TEST = 11;

  // global command and diagnostic fields
  localparam int GLOB_DAC_LATCH = 2;
  localparam int DIAG_MEM_FAIL = 6;
  localparam int DIAG_ST_FAIL = 5;
  localparam logic [15:0] DIAG_STICKY_MASK = 16'h037c;
  localparam logic [11:0] DAC_RESET = 12'h000;

  // interrupt status bits
  localparam int IRQ_DRDY = 0;
  localparam int IRQ_MEM_DONE = 1;
  localparam int IRQ_ST_DONE = 2;
  localparam int IRQ_DIAG = 3;

  // timing
  localparam int CLK_MHZ = 100;
  localparam int DRDY_MIN_US = 100;
  localparam int DRDY_MAX_US = 200;
  localparam int DRDY_PULSE_CYC = DRDY_MIN_US * CLK_MHZ;
  localparam logic [15:0] MEM_TEST_CYC = 16'h0100;
  localparam logic [15:0] ST_SETTLE_CYC = 16'h0400;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MEM = 3'b010,
    ST_AUTO = 3'b100
  } dsr_fsm_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } dsr_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dsr_apb_rsp_t;

  typedef struct packed {
    logic [2:0] dr_cfg;
    logic st_pos;
    logic st_neg;
    logic st_auto;
    logic mem_test;
    logic [11:0] dac_hold;
    logic [11:0] dac_out;
    logic dac_latch;
    logic [15:0] flash_write_counter;
    logic [15:0] diag_flags;
    dsr_fsm_t fsm;
    logic [15:0] test_cnt;
    logic [15:0] dr_cnt;
    logic dr_act;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [15:0] rd_hold;
  } dsr_state_t;
endpackage

// ---- design/dsr_diag_ctrl.sv ----
// Purpose: data ready line control, aux dac latch, flash write counter, self-test and memory test, diagnostic flags
// Assumes: apb slave with zero wait states; sample_tick marks each new sample
// Assumes: read data is captured at the setup edge and held through the access cycle
// Notes: sensor, flash and supply monitors are outside; this block sequences and records sensor and flash, supply flags read live
// Notes: the pulse width is a plain cycle count, so it scales with the clock period
// Notes: both general lines carry the same level; only the enables pick the line
`timescale 1ns/10ps
module dsr_diag_ctrl
  import dsr_pkg::*;
#(
  parameter int DRDY_CYC = DRDY_PULSE_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register bus
  input wire dsr_apb_req_t apb_req,
  output dsr_apb_rsp_t apb_rsp,
  // sensor side
  input wire logic sample_tick,
  input wire logic st_resp_ok,
  output logic st_stim_pos,
  output logic st_stim_neg,
  // memory and flash
  input wire logic flash_write_done,
  input wire logic [15:0] flash_checksum,
  input wire logic [15:0] sram_checksum,
  // error conditions, bits 9:8 and 6:2 used
  input wire logic [15:0] err_cond,
  input wire logic supply_high,
  input wire logic supply_low,
  // aux dac
  output logic [11:0] dac_code,
  // general purpose lines
  output logic general_line_one_out,
  output logic general_line_one_oe,
  output logic general_line_two_out,
  output logic general_line_two_oe,
  // interrupt
  output logic irq
);

  dsr_state_t s;
  dsr_state_t next_s;
  logic wr;
  logic rd;
  logic [7:0] idx;
  logic hit;
  logic [15:0] diag_view;
  logic [15:0] diag_set;
  logic [15:0] rdata;
  logic [3:0] ev;
  logic dr_level;

  // setup phase, completion and start strobes
  logic setup;
  logic mem_done;
  logic st_done;
  logic dr_start;

  // per-bit flag and interrupt updates
  logic [15:0] diag_clr;
  logic [15:0] flag_new;
  logic [15:0] next_flags;
  logic [3:0] irq_clr;
  logic [3:0] next_irq;

  // data ready per line, index 0 is line one
  logic [1:0] line_out;
  logic [1:0] line_oe;

  // one select per mapped register
  localparam logic [7:0] MAP_IDX [7] = '{IDX_FLASH_WRITE_COUNTER, IDX_AUX_DAC, IDX_MISC, IDX_DIAG,
                                         IDX_GLOB, IDX_IRQ_STAT, IDX_IRQ_MASK};
  logic [6:0] reg_sel;

  // bus decode; no wait states so every access ends in its first access cycle
  assign idx = apb_req.paddr[ADDR_W-1:2];
  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
  // setup cycle, when the read word is captured
  assign setup = apb_req.psel & ~apb_req.penable;

  // address match per register; anything else is refused with pslverr
  for (genvar gr = 0; gr < 7; gr++) begin : g_map
    assign reg_sel[gr] = (idx == MAP_IDX[gr]);
  end
  assign hit = |reg_sel;

  assign diag_view = (s.diag_flags & DIAG_STICKY_MASK) | {14'h0000, supply_high, supply_low};

  // read mux, unused bits read zero
  always_comb begin
    rdata = 16'h0000;
    case (idx)
      IDX_FLASH_WRITE_COUNTER: rdata = s.flash_write_counter;
      IDX_AUX_DAC: rdata = {4'h0, s.dac_hold};
      IDX_MISC: rdata = {4'h0, s.mem_test, s.st_auto, s.st_neg, s.st_pos, 5'h00, s.dr_cfg};
      IDX_DIAG: rdata = diag_view;
      IDX_GLOB: rdata = {13'h0000, s.dac_latch, 2'h0};
      IDX_IRQ_STAT: rdata = {12'h000, s.irq_stat};
      IDX_IRQ_MASK: rdata = {12'h000, s.irq_mask};
      default: rdata = 16'h0000;
    endcase
  end

  // apb answer; read data comes from the word captured at the setup edge,
  // so the bus sees a flop and the clear-on-read knows exactly what went out
  assign apb_rsp.pready = apb_req.psel & apb_req.penable;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~hit;
  assign apb_rsp.prdata = {16'h0000, s.rd_hold};

  // test completion strobes, shared by the sequencer and the flag logic
  assign mem_done = (s.fsm == ST_MEM) && (s.test_cnt == MEM_TEST_CYC);
  assign st_done = (s.fsm == ST_AUTO) && (s.test_cnt == ST_SETTLE_CYC);

  // a pulse starts only from rest, so a tick mid-pulse is ignored
  assign dr_start = ~s.dr_act & sample_tick & s.dr_cfg[MISC_DR_EN];

  // flag sources: sample relatch and test verdicts
  always_comb begin
    diag_set = 16'h0000;
    if (sample_tick) begin
      diag_set = err_cond & DIAG_STICKY_MASK;
    end
    // checksum compare as the memory test ends
    if (mem_done) begin
      diag_set[DIAG_MEM_FAIL] = (flash_checksum != sram_checksum);
    end
    if (st_done) begin
      diag_set[DIAG_ST_FAIL] = ~st_resp_ok;
    end
  end

  // only bits that went out in the captured word are cleared
  // a flag landing between setup and access is still unread and stays
  assign diag_clr = (rd && idx == IDX_DIAG) ? (s.rd_hold & DIAG_STICKY_MASK) : 16'h0000;

  // interrupt status is write one to clear on lane 0
  assign irq_clr = (wr && idx == IDX_IRQ_STAT && apb_req.pstrb[0]) ? apb_req.pwdata[3:0] : 4'h0;

  // per-bit sticky flags; a set in the clear cycle wins
  for (genvar gi = 0; gi < 16; gi++) begin : g_flag
    assign next_flags[gi] = DIAG_STICKY_MASK[gi] & (diag_set[gi] | (s.diag_flags[gi] & ~diag_clr[gi]));
    assign flag_new[gi] = diag_set[gi] & ~s.diag_flags[gi];
  end

  // events in interrupt bit order
  assign ev[IRQ_DRDY] = dr_start;
  assign ev[IRQ_MEM_DONE] = mem_done;
  assign ev[IRQ_ST_DONE] = st_done;
  assign ev[IRQ_DIAG] = |flag_new;

  // a new event beats a clear in the same cycle, so none is lost
  for (genvar gj = 0; gj < 4; gj++) begin : g_irq
    assign next_irq[gj] = ev[gj] | (s.irq_stat[gj] & ~irq_clr[gj]);
  end

  // next-state logic
  always_comb begin
    next_s = s;

    // capture the read word at the setup edge, kept until the next setup
    if (setup) begin
      next_s.rd_hold = rdata;
    end

    // flash write counting, saturates rather than wrapping to zero
    if (flash_write_done && s.flash_write_counter != 16'hffff) begin
      next_s.flash_write_counter = s.flash_write_counter + 16'h0001;
    end

    // dac latch completes one cycle after the command
    if (s.dac_latch) begin
      next_s.dac_out = s.dac_hold;
      next_s.dac_latch = 1'b0;
    end

    // test sequencer, memory test has priority over self-test;
    // a pending self-test waits in its start bit until the sequencer is free
    case (s.fsm)
      ST_IDLE: begin
        next_s.test_cnt = 16'h0000;
        if (s.mem_test) begin
          next_s.fsm = ST_MEM;
        end else if (s.st_auto) begin
          next_s.fsm = ST_AUTO;
        end
      end
      ST_MEM: begin
        next_s.test_cnt = s.test_cnt + 16'h0001;
        if (mem_done) begin
          next_s.mem_test = 1'b0;
          next_s.fsm = ST_IDLE;
        end
      end
      ST_AUTO: begin
        next_s.test_cnt = s.test_cnt + 16'h0001;
        if (st_done) begin
          next_s.st_auto = 1'b0;
          next_s.fsm = ST_IDLE;
        end
      end
      default: begin
        next_s.fsm = ST_IDLE;
      end
    endcase

    // pulse timer holds for the full width; a tick mid-pulse is ignored
    if (s.dr_act) begin
      next_s.dr_cnt = s.dr_cnt - 16'h0001;
      if (s.dr_cnt == 16'h0001) begin
        next_s.dr_act = 1'b0;
      end
    end else if (dr_start) begin
      // full width is loaded at once; the minimum width is the safe end
      next_s.dr_act = 1'b1;
      next_s.dr_cnt = 16'(DRDY_CYC);
    end

    // register writes
    if (wr) begin
      case (idx)
        IDX_AUX_DAC: begin
          // byte lanes fill the holding register only
          if (apb_req.pstrb[0]) begin
            next_s.dac_hold[7:0] = apb_req.pwdata[7:0];
          end
          if (apb_req.pstrb[1]) begin
            next_s.dac_hold[11:8] = apb_req.pwdata[11:8];
          end
        end
        IDX_MISC: begin
          if (apb_req.pstrb[0]) begin
            next_s.dr_cfg = apb_req.pwdata[2:0];
          end
          if (apb_req.pstrb[1]) begin
            next_s.st_pos = apb_req.pwdata[MISC_ST_POS];
            next_s.st_neg = apb_req.pwdata[MISC_ST_NEG];
            // writing one starts, zero cannot abort
            next_s.st_auto = next_s.st_auto | apb_req.pwdata[MISC_ST_AUTO];
            next_s.mem_test = next_s.mem_test | apb_req.pwdata[MISC_MEM_TEST];
          end
        end
        IDX_GLOB: begin
          if (apb_req.pstrb[0] && apb_req.pwdata[GLOB_DAC_LATCH]) begin
            next_s.dac_latch = 1'b1;
          end
        end
        IDX_IRQ_MASK: begin
          if (apb_req.pstrb[0]) begin
            next_s.irq_mask = apb_req.pwdata[3:0];
          end
        end
        default: begin
        end
      endcase
    end

    // clear on read and relatch, worked out per bit above
    next_s.diag_flags = next_flags;

    // interrupt status, write one to clear, new event wins
    next_s.irq_stat = next_irq;
  end

  // state register; reset loads constants only, the rest follows next_s
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s.dr_cfg <= MISC_RESET[2:0];
      s.st_pos <= 1'b0;
      s.st_neg <= 1'b0;
      s.st_auto <= 1'b0;
      s.mem_test <= 1'b0;
      s.dac_hold <= DAC_RESET;
      s.dac_out <= DAC_RESET;
      s.dac_latch <= 1'b0;
      s.flash_write_counter <= 16'h0000;
      s.diag_flags <= 16'h0000;
      s.fsm <= ST_IDLE;
      s.test_cnt <= 16'h0000;
      s.dr_cnt <= 16'h0000;
      s.dr_act <= 1'b0;
      s.irq_stat <= 4'h0;
      s.irq_mask <= 4'h0;
      s.rd_hold <= 16'h0000;
    end else begin
      s <= next_s;
    end
  end

  // stimulus outputs; auto test borrows the positive drive
  assign st_stim_pos = s.st_pos | (s.fsm == ST_AUTO);
  assign st_stim_neg = s.st_neg;

  assign dac_code = s.dac_out;

  // polarity low makes the active state a low pulse
  assign dr_level = s.dr_cfg[MISC_DR_POL] ? s.dr_act : ~s.dr_act;
  // line select; the unselected line is left undriven so that
  // other functions sharing the pin are not fought
  for (genvar gl = 0; gl < 2; gl++) begin : g_line
    assign line_out[gl] = dr_level;
    assign line_oe[gl] = s.dr_cfg[MISC_DR_EN] & (s.dr_cfg[MISC_DR_SEL] == 1'(gl));
  end

  // pins, line one first
  assign general_line_one_out = line_out[0];
  assign general_line_one_oe = line_oe[0];
  assign general_line_two_out = line_out[1];
  assign general_line_two_oe = line_oe[1];

  // level interrupt from unmasked sticky bits
  assign irq = |(s.irq_stat & s.irq_mask);

endmodule

// ---- dv/dsr_diag_ctrl_assertions.sv ----
// Purpose: bus and pin checks for the diagnostics block
// Assumes: zero wait state apb slave
// Notes: pulse width is measured by the bench
`timescale 1ns/10ps
module dsr_diag_ctrl_assertions
  import dsr_pkg::*;
(
  // clock, reset and bus
  input wire logic ref_clk,
  input wire logic rstn,
  input wire dsr_apb_req_t apb_req,
  input wire dsr_apb_rsp_t apb_rsp,
  // pins
  input wire logic supply_high,
  input wire logic supply_low,
  input wire logic st_stim_pos,
  input wire logic st_stim_neg,
  input wire logic [11:0] dac_code,
  input wire logic general_line_one_oe,
  input wire logic general_line_two_oe,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // decoded accesses
  logic acc, wr, wm, gl;
  logic [9:0] a;
  logic [31:0] d;
  assign a = apb_req.paddr;
  assign d = apb_req.pwdata;
  assign acc = apb_req.psel && apb_req.penable;
  assign wr = acc && apb_req.pwrite;
  assign wm = wr && a == 10'h0d0 && apb_req.pstrb[1];
  assign gl = wr && a == 10'h0f8 && apb_req.pstrb[0] && d[GLOB_DAC_LATCH];
  bus_ready_a: assert property (acc |-> apb_rsp.pready) else $error("pready missing");
  bad_addr_a: assert property (acc && a == 10'h008 |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
    else $error("unmapped access not refused");
  dac_latch_a: assert property ($changed(dac_code) |-> $past(gl, 2)) else $error("dac moved without latch");
  supply_live_a: assert property (acc && !apb_req.pwrite && a == 10'h0f0 |->
    apb_rsp.prdata[1:0] == $past({supply_high, supply_low})) else $error("supply flags not live");
  stim_neg_a: assert property (wm |=> st_stim_neg == $past(d[MISC_ST_NEG])) else $error("negative stimulus wrong");
  stim_pos_a: assert property (wm && d[MISC_ST_POS] |=> st_stim_pos) else $error("positive stimulus missing");
  auto_stim_a: assert property (wm && d[MISC_ST_AUTO] && !d[MISC_MEM_TEST] |-> ##[1:4] st_stim_pos)
    else $error("self-test stimulus missing");
  irq_mask_a: assert property (wr && a == 10'h104 && apb_req.pstrb[0] && d[3:0] == 4'h0 |=> !irq)
    else $error("masked interrupt raised");
  one_line_a: assert property (!(general_line_one_oe && general_line_two_oe)) else $error("both lines driven");
  // main scenarios reached
  cov_latch: cover property (gl);
  cov_auto: cover property (wm && d[MISC_ST_AUTO]);
  cov_line2: cover property (general_line_two_oe);
endmodule
bind dsr_diag_ctrl dsr_diag_ctrl_assertions chk_i (.ref_clk(ref_clk), .rstn(rstn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .supply_high(supply_high), .supply_low(supply_low), .st_stim_pos(st_stim_pos),
  .st_stim_neg(st_stim_neg), .dac_code(dac_code), .general_line_one_oe(general_line_one_oe),
  .general_line_two_oe(general_line_two_oe), .irq(irq));

// ---- dv/dsr_host.sv ----
// Purpose: host model issuing apb transfers
// Assumes: called right after a rising edge
// Notes: raises hung when no answer comes
`timescale 1ns/10ps
module dsr_host
  import dsr_pkg::*;
(
  // clock and bus
  input wire logic ref_clk,
  output dsr_apb_req_t apb_req,
  input wire dsr_apb_rsp_t apb_rsp,
  // status
  output logic hung
);
  initial begin
    apb_req = '0;
    hung = 1'b0;
  end
  // setup, then access held until pready at an edge
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
    int n;
    n = 0;
    apb_req <= '{1'b1, 1'b0, w, a, d, s};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    q = apb_rsp.prdata;
    hung <= (n >= 50);
    apb_req <= '0;
    @(posedge ref_clk);
  endtask
endmodule

// ---- dv/dsr_diag_ctrl_test.sv ----
// Purpose: self-checking bench for the diagnostics block
// Assumes: all register traffic goes through dsr_host
// Notes: pulse width shortened to DR cycles
`timescale 1ns/10ps
module dsr_diag_ctrl_test;
  import dsr_pkg::*;
  localparam int DR = 20;
  localparam logic [9:0] AM = {IDX_MISC, 2'b00};
  localparam logic [9:0] AD = {IDX_DIAG, 2'b00};
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic sample_tick = 1'b0;
  logic st_resp_ok = 1'b1;
  logic flash_write_done = 1'b0;
  logic supply_high = 1'b0;
  logic supply_low = 1'b0;
  logic watch = 1'b0;
  logic [15:0] flash_checksum = 16'h0;
  logic [15:0] sram_checksum = 16'h0;
  logic [15:0] err_cond = 16'h0;
  logic pos, neg, l1o, l1e, l2o, l2e, irq, hung;
  logic [11:0] dac_code;
  logic [15:0] v;
  logic [31:0] q;
  logic [15:0] exp_q[$];
  dsr_apb_req_t apb_req;
  dsr_apb_rsp_t apb_rsp;
  int error_cnt = 0;
  int cmp_count = 0;
  int seed = 32'h011dc0dc;
  int k;
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  dsr_diag_ctrl #(.DRDY_CYC(DR)) uut (.ref_clk(ref_clk), .rstn(rstn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .sample_tick(sample_tick), .st_resp_ok(st_resp_ok), .st_stim_pos(pos), .st_stim_neg(neg),
    .flash_write_done(flash_write_done), .flash_checksum(flash_checksum), .sram_checksum(sram_checksum),
    .err_cond(err_cond), .supply_high(supply_high), .supply_low(supply_low), .dac_code(dac_code),
    .general_line_one_out(l1o), .general_line_one_oe(l1e), .general_line_two_out(l2o),
    .general_line_two_oe(l2e), .irq(irq));
  dsr_host host (.ref_clk(ref_clk), .apb_req(apb_req), .apb_rsp(apb_rsp), .hung(hung));
  task automatic test_done;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // one idle edge is left after each write so registered pins settle
  task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic [3:0] s = 4'h3);
    host.xfer(1'b1, a, {16'h0, d}, s, q);
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    watch = 1'b1;
    host.xfer(1'b0, a, 32'h0, 4'h0, q);
    watch = 1'b0;
  endtask
  task automatic poll(input int b);
    k = 0;
    do begin
      host.xfer(1'b0, AM, 32'h0, 4'h0, q);
      k++;
    end while (q[b] !== 1'b0 && k < 600);
    if (k >= 600) begin
      error_cnt++;
      test_done();
    end
  endtask
  task automatic tick;
    sample_tick <= 1'b1;
    @(posedge ref_clk);
    sample_tick <= 1'b0;
  endtask
  // measure one data ready pulse on the chosen line
  task automatic drdy(input logic two, input logic act);
    int n;
    n = 0;
    tick();
    while ((two ? l2o : l1o) !== act && n < 5) begin
      @(posedge ref_clk);
      n++;
    end
    n = 0;
    while ((two ? l2o : l1o) === act && n < 3 * DR) begin
      @(posedge ref_clk);
      n++;
    end
    chk("drdy_width", 16'(n), 16'(DR));
    chk("drdy_oe", {14'h0, l1e, l2e}, {14'h0, !two, two});
  endtask
  // read results against the oldest note
  always @(posedge ref_clk) begin
    if (watch && apb_req.psel && apb_req.penable && apb_rsp.pready)
      chk("prdata", exp_q.pop_front(), apb_rsp.prdata[15:0]);
  end
  always @(posedge hung) begin
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd(AM, MISC_RESET);
    chk("reset_pins", {13'h0, l1e, l1o, l2e}, 16'h0004);
    for (int i = 4; i < 8; i++) begin
      wr(AM, 16'(i));
      drdy(i[0], i[1]);
    end
    wr(AM, 16'h0000);
    chk("drdy_off", {14'h0, l1e, l2e}, 16'h0000);
    // interrupt from the data ready event, unmasked then cleared
    wr({IDX_IRQ_MASK, 2'b00}, 16'h0001);
    chk("irq", {15'h0, irq}, 16'h0001);
    wr({IDX_IRQ_STAT, 2'b00}, 16'h000f);
    chk("irq", {15'h0, irq}, 16'h0000);
    v = 16'($random(seed)) & 16'h0fff;
    wr({IDX_AUX_DAC, 2'b00}, v & 16'h00ff, 4'h1);
    wr({IDX_AUX_DAC, 2'b00}, v & 16'h0f00, 4'h2);
    chk("dac_code", {4'h0, dac_code}, 16'h0000);
    rd({IDX_AUX_DAC, 2'b00}, v);
    wr({IDX_GLOB, 2'b00}, 16'h0004);
    chk("dac_code", {4'h0, dac_code}, v);
    rd({IDX_GLOB, 2'b00}, 16'h0000);
    k = 1 + ($random(seed) & 7);
    repeat (k) begin
      flash_write_done <= 1'b1;
      @(posedge ref_clk);
      flash_write_done <= 1'b0;
      @(posedge ref_clk);
    end
    rd({IDX_FLASH_WRITE_COUNTER, 2'b00}, 16'(k));
    v = 16'($random(seed));
    flash_checksum <= v;
    sram_checksum <= v ^ 16'h0001;
    wr(AM, 16'h0800, 4'h2);
    poll(MISC_MEM_TEST);
    rd(AD, 16'h0040);
    rd(AD, 16'h0000);
    st_resp_ok <= 1'b0;
    wr(AM, 16'h0400, 4'h2);
    poll(MISC_ST_AUTO);
    rd(AD, 16'h0020);
    // manual stimulus in host order: negative, positive, off
    wr(AM, 16'h0200, 4'h2);
    chk("stim", {14'h0, pos, neg}, 16'h0001);
    wr(AM, 16'h0100, 4'h2);
    chk("stim", {14'h0, pos, neg}, 16'h0002);
    wr(AM, 16'h0000, 4'h2);
    chk("stim", {14'h0, pos, neg}, 16'h0000);
    err_cond <= 16'h0010;
    tick();
    rd(AD, 16'h0010);
    rd(AD, 16'h0000);
    tick();
    rd(AD, 16'h0010);
    err_cond <= 16'h0000;
    supply_high <= 1'b1;
    supply_low <= 1'b1;
    rd(AD, 16'h0003);
    supply_high <= 1'b0;
    supply_low <= 1'b0;
    rd(AD, 16'h0000);
    rd(10'h008, 16'h0000);
    wr({IDX_IRQ_MASK, 2'b00}, 16'h0000);
    test_done();
  end
endmodule
